// ===== design/pfm_top.v
/*
  Port function mux for ports 0 to 4 with mode registers, port
  latches, pin level readback and the PLL divider register, on APB.
  Assumes APB master on core_clk_in; external memory, card interface
  and SPI controls arrive on the same clock; pad pins are asynchronous.
*/
// Summary of operation
// - pll divider holds R high, N low
// - pll divider clears to zero on reset
// - port 0 drives address/data strongly during access when ext_data_drive_in, else floats ones
// - port 0 default open drain, ones float
// - port 0 offers low speed, push-pull modes
// - port 1 mostly card pins, three standard
// - card io/contacts quasi, low at reset
// - presence quasi high, pull-ups removable
// - card clock/reset push-pull, low at reset
// - port 1 pin 6 is quasi slave select
// - pin 1.7 push-pull when alt clock enabled
// - port 2 drives high address during access
// - port 2 push-pull, low speed, weak input
// - ports 2-4 default quasi bidirectional
// - port 3 pins 0,1,3,4 take modes 1-3
// - port 3 pins 2,4,6,7 LED drive mode
// - pins 3.6/3.7 carry write/read strobes
// - port 4 six pins, per-pin alternates
// - port 4 pins 0-2 carry SPI signals
`timescale 1ns/100ps
`default_nettype none
`include "pfm_regs.vh"

module pfm_top #(
  parameter N_PINS = 38
) (
  input wire core_clk_in,
  input wire reset_in,
  input wire psel_in,
  input wire penable_in,
  input wire pwrite_in,
  input wire [7:0] paddr_in,
  input wire [31:0] pwdata_in,
  output wire pready_out,
  output reg [31:0] prdata_out,
  output reg pslverr_out,
  input wire ext_mem_access_in,
  input wire ext_data_drive_in,
  input wire [7:0] ext_addr_data_lo_in,
  input wire [7:0] ext_addr_hi_in,
  input wire ext_wr_strobe_n_in,
  input wire ext_rd_strobe_n_in,
  output reg [7:0] ext_read_data_out,
  input wire card_io_line_in,
  input wire card_contact_eight_in,
  input wire card_contact_four_in,
  input wire card_clock_out_in,
  input wire card_reset_out_in,
  input wire alternate_card_clock_in,
  input wire [2:0] spi_data_in,
  input wire [2:0] spi_oe_in,
  input wire [N_PINS-1:0] pin_in,
  output wire [N_PINS-1:0] pin_out,
  output wire [N_PINS-1:0] pin_oe_out,
  output wire [N_PINS-1:0] weak_pu_out,
  output wire [N_PINS-1:0] medium_pu_out,
  output wire [N_PINS-1:0] slow_out,
  output wire [N_PINS-1:0] led_out,
  output reg [N_PINS-1:0] pin_level_out,
  output wire [3:0] pll_r_divider_out,
  output wire [3:0] pll_n_divider_out
);

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  reg [7:0] pll_divider_q;
  reg [7:0] mode0_q;
  reg [7:0] mode1_q;
  reg [7:0] aux_q;
  reg [7:0] latch0_q;
  reg [7:0] latch1_q;
  reg [7:0] latch2_q;
  reg [7:0] latch3_q;
  reg [5:0] latch4_q;
  reg [N_PINS-1:0] sync1_q;
  reg [N_PINS-1:0] sync2_q;
  reg [N_PINS-1:0] sync3_q;
  reg [31:0] rd_data_c;
  reg hit_c;
  reg ro_c;
  reg [3*N_PINS-1:0] kind_c;
  reg [N_PINS-1:0] data_c;
  reg [N_PINS-1:0] wdis_c;
  reg [N_PINS-1:0] mdis_c;
  integer i;

  wire wr_en;
  wire setup_phase;
  wire wpu_dis;
  wire alt_clk_en;
  wire smart_card_interface_block_en;
  wire spi_en;
  wire pres_disc;
  wire [1:0] p0_mode;
  wire [1:0] p2_mode;
  wire [1:0] p3_mode;
  wire [1:0] p4_mode;
  wire [3:0] led_en;

  assign pready_out = 1'b1;
  assign setup_phase = psel_in & ~penable_in;
  assign wr_en = psel_in & penable_in & pwrite_in & hit_c & ~ro_c;
  assign wpu_dis = aux_q[`PFM_AUX_WPU_DIS];
  assign alt_clk_en = aux_q[`PFM_AUX_ALT_CLK_EN];
  assign smart_card_interface_block_en = aux_q[`PFM_AUX_SMART_CARD_INTERFACE_BLOCK_EN];
  assign spi_en = aux_q[`PFM_AUX_SPI_EN];
  assign pres_disc = mode0_q[`PFM_M0_PRES_DISC];
  assign p0_mode = mode0_q[`PFM_M0_P0_LSB +: 2];
  assign p2_mode = mode0_q[`PFM_M0_P2_LSB +: 2];
  assign p3_mode = mode0_q[`PFM_M0_P3_LSB +: 2];
  assign p4_mode = mode1_q[`PFM_M1_P4_LSB +: 2];
  assign led_en = mode1_q[`PFM_M1_LED_LSB +: 4];
  assign pll_r_divider_out = pll_divider_q[`PFM_PLL_R_MSB:`PFM_PLL_R_LSB];
  assign pll_n_divider_out = pll_divider_q[`PFM_PLL_N_MSB:`PFM_PLL_N_LSB];

  // mode codes 1..3 map to push-pull, low speed, a port-specific input
  function [2:0] mode_kind;
    input [1:0] code;
    input [2:0] kind3;
    begin
      case (code)
        2'h1: mode_kind = `PFM_K_PUSH_PULL;
        2'h2: mode_kind = `PFM_K_LOW_SPEED;
        2'h3: mode_kind = kind3;
        default: mode_kind = `PFM_K_QUASI;
      endcase
    end
  endfunction

  // ----------------------------------------------------------------
  // apb decode and readback
  // ----------------------------------------------------------------
  always @*
  begin
    rd_data_c = 32'h0000_0000;
    hit_c = 1'b1;
    case (paddr_in)
      `PFM_OFF_PLL_DIVIDER: rd_data_c[7:0] = pll_divider_q;
      `PFM_OFF_MODE0: rd_data_c[7:0] = mode0_q;
      `PFM_OFF_MODE1: rd_data_c[7:0] = mode1_q;
      `PFM_OFF_AUX: rd_data_c[7:0] = aux_q;
      `PFM_OFF_LATCH0: rd_data_c[7:0] = latch0_q;
      `PFM_OFF_LATCH1: rd_data_c[7:0] = latch1_q;
      `PFM_OFF_LATCH2: rd_data_c[7:0] = latch2_q;
      `PFM_OFF_LATCH3: rd_data_c[7:0] = latch3_q;
      `PFM_OFF_LATCH4: rd_data_c[5:0] = latch4_q;
      `PFM_OFF_LEVEL0: rd_data_c[7:0] = pin_level_out[7:0];
      `PFM_OFF_LEVEL1: rd_data_c[7:0] = pin_level_out[15:8];
      `PFM_OFF_LEVEL2: rd_data_c[7:0] = pin_level_out[23:16];
      `PFM_OFF_LEVEL3: rd_data_c[7:0] = pin_level_out[31:24];
      `PFM_OFF_LEVEL4: rd_data_c[5:0] = pin_level_out[37:32];
      default: hit_c = 1'b0;
    endcase
    ro_c = hit_c & (paddr_in >= `PFM_OFF_LEVEL0) & (paddr_in <= `PFM_OFF_LEVEL4);
  end

  // read data and error are captured in the setup cycle
  always @(posedge core_clk_in)
  begin
    if (reset_in)
    begin
      prdata_out <= 32'h0000_0000;
      pslverr_out <= 1'b0;
    end
    else if (setup_phase)
    begin
      prdata_out <= pwrite_in ? 32'h0000_0000 : rd_data_c;
      pslverr_out <= ~hit_c | (pwrite_in & ro_c);
    end
  end

  // ----------------------------------------------------------------
  // software registers
  // ----------------------------------------------------------------
  always @(posedge core_clk_in)
  begin
    if (reset_in)
    begin
      pll_divider_q <= `PFM_RST_PLL_DIVIDER;
      mode0_q <= `PFM_RST_MODE;
      mode1_q <= `PFM_RST_MODE;
      aux_q <= `PFM_RST_AUX;
      latch0_q <= `PFM_RST_LATCH;
      latch1_q <= `PFM_RST_LATCH;
      latch2_q <= `PFM_RST_LATCH;
      latch3_q <= `PFM_RST_LATCH;
      latch4_q <= `PFM_RST_LATCH4;
    end
    else if (wr_en)
    begin
      case (paddr_in)
        `PFM_OFF_PLL_DIVIDER: pll_divider_q <= pwdata_in[7:0];
        `PFM_OFF_MODE0: mode0_q <= pwdata_in[7:0];
        `PFM_OFF_MODE1: mode1_q <= pwdata_in[7:0];
        `PFM_OFF_AUX: aux_q <= pwdata_in[7:0];
        `PFM_OFF_LATCH0: latch0_q <= pwdata_in[7:0];
        `PFM_OFF_LATCH1: latch1_q <= pwdata_in[7:0];
        `PFM_OFF_LATCH2: latch2_q <= pwdata_in[7:0];
        `PFM_OFF_LATCH3: latch3_q <= pwdata_in[7:0];
        `PFM_OFF_LATCH4: latch4_q <= pwdata_in[5:0];
        default: latch4_q <= latch4_q;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // pin input synchroniser and filter
  // ----------------------------------------------------------------
  always @(posedge core_clk_in)
  begin
    if (reset_in)
    begin
      sync1_q <= {N_PINS{1'b1}};
      sync2_q <= {N_PINS{1'b1}};
      sync3_q <= {N_PINS{1'b1}};
      pin_level_out <= {N_PINS{1'b1}};
      ext_read_data_out <= 8'hFF;
    end
    else
    begin
      sync1_q <= pin_in;
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
      // level follows only where the last two stages agree
      pin_level_out <= (sync2_q & sync3_q) | (pin_level_out & (sync2_q ^ sync3_q));
      ext_read_data_out <= pin_level_out[7:0];
    end
  end

  // ----------------------------------------------------------------
  // pin function selection
  // ----------------------------------------------------------------
  always @*
  begin
    kind_c = {3*N_PINS{1'b0}};
    data_c = {N_PINS{1'b1}};
    wdis_c = {N_PINS{1'b0}};
    mdis_c = {N_PINS{1'b0}};
    // port 0
    for (i = 0; i < 8; i = i + 1)
    begin
      if (ext_mem_access_in)
      begin
        kind_c[3*i +: 3] = ext_data_drive_in ? `PFM_K_PUSH_PULL : `PFM_K_OPEN_DRAIN;
        data_c[i] = ext_data_drive_in ? ext_addr_data_lo_in[i] : 1'b1;
      end
      else
      begin
        case (p0_mode)
          2'h2: kind_c[3*i +: 3] = `PFM_K_LOW_SPEED;
          2'h3: kind_c[3*i +: 3] = `PFM_K_PUSH_PULL;
          default: kind_c[3*i +: 3] = `PFM_K_OPEN_DRAIN;
        endcase
        data_c[i] = latch0_q[i];
      end
    end
    // port 1: card contacts, presence, slave select, alternate clock
    kind_c[3*8 +: 3] = `PFM_K_QUASI;
    data_c[8] = smart_card_interface_block_en & card_io_line_in;
    wdis_c[8] = wpu_dis;
    kind_c[3*9 +: 3] = `PFM_K_QUASI;
    data_c[9] = smart_card_interface_block_en & card_contact_eight_in;
    wdis_c[9] = wpu_dis;
    kind_c[3*10 +: 3] = `PFM_K_QUASI;
    data_c[10] = latch1_q[2];
    wdis_c[10] = pres_disc;
    mdis_c[10] = pres_disc;
    kind_c[3*11 +: 3] = `PFM_K_QUASI;
    data_c[11] = smart_card_interface_block_en & card_contact_four_in;
    wdis_c[11] = wpu_dis;
    kind_c[3*12 +: 3] = `PFM_K_PUSH_PULL;
    data_c[12] = smart_card_interface_block_en & card_clock_out_in;
    kind_c[3*13 +: 3] = `PFM_K_PUSH_PULL;
    data_c[13] = smart_card_interface_block_en & card_reset_out_in;
    kind_c[3*14 +: 3] = `PFM_K_QUASI;
    data_c[14] = latch1_q[6];
    kind_c[3*15 +: 3] = alt_clk_en ? `PFM_K_PUSH_PULL : `PFM_K_QUASI;
    data_c[15] = alt_clk_en ? alternate_card_clock_in : latch1_q[7];
    // port 2
    for (i = 0; i < 8; i = i + 1)
    begin
      if (ext_mem_access_in)
      begin
        kind_c[3*(16+i) +: 3] = `PFM_K_PUSH_PULL;
        data_c[16+i] = ext_addr_hi_in[i];
      end
      else
      begin
        kind_c[3*(16+i) +: 3] = mode_kind(p2_mode, `PFM_K_WPU_IN);
        data_c[16+i] = latch2_q[i];
      end
    end
    // port 3
    for (i = 0; i < 8; i = i + 1)
    begin
      data_c[24+i] = latch3_q[i];
      kind_c[3*(24+i) +: 3] = `PFM_K_QUASI;
      if (i == 0 || i == 1 || i == 3 || i == 4)
        kind_c[3*(24+i) +: 3] = mode_kind(p3_mode, `PFM_K_WPU_IN);
    end
    if (led_en[0])
      kind_c[3*26 +: 3] = `PFM_K_LED;
    if (led_en[1])
      kind_c[3*28 +: 3] = `PFM_K_LED;
    if (led_en[2])
      kind_c[3*30 +: 3] = `PFM_K_LED;
    if (led_en[3])
      kind_c[3*31 +: 3] = `PFM_K_LED;
    if (ext_mem_access_in)
    begin
      kind_c[3*30 +: 3] = `PFM_K_PUSH_PULL;
      data_c[30] = ext_wr_strobe_n_in;
      kind_c[3*31 +: 3] = `PFM_K_PUSH_PULL;
      data_c[31] = ext_rd_strobe_n_in;
    end
    // port 4
    for (i = 0; i < 6; i = i + 1)
    begin
      data_c[32+i] = latch4_q[i];
      if (i < 3)
      begin
        kind_c[3*(32+i) +: 3] = `PFM_K_QUASI;
        if (spi_en)
        begin
          kind_c[3*(32+i) +: 3] = spi_oe_in[i] ? `PFM_K_PUSH_PULL : `PFM_K_QUASI;
          data_c[32+i] = spi_oe_in[i] ? spi_data_in[i] : 1'b1;
        end
      end
      else
        kind_c[3*(32+i) +: 3] = mode_kind(p4_mode, `PFM_K_MPU_IN);
    end
  end

  // ----------------------------------------------------------------
  // pad driver cells
  // ----------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < N_PINS; g = g + 1)
    begin : g_pin
      pfm_pin_cell u_cell (
        .core_clk_in(core_clk_in),
        .reset_in(reset_in),
        .kind_in(kind_c[3*g +: 3]),
        .data_in(data_c[g]),
        .pin_level_in(pin_level_out[g]),
        .weak_dis_in(wdis_c[g]),
        .medium_dis_in(mdis_c[g]),
        .pin_out(pin_out[g]),
        .pin_oe_out(pin_oe_out[g]),
        .weak_pu_out(weak_pu_out[g]),
        .medium_pu_out(medium_pu_out[g]),
        .slow_out(slow_out[g]),
        .led_out(led_out[g])
      );
    end
  endgenerate

endmodule // pfm_top

`default_nettype wire

// ===== design/pfm_regs.vh
/*
  Register offsets, field positions, reset values and pin drive kinds
  of the port function mux and PLL divider block.
  Assumes inclusion by bare name from design files of this block.
*/
`ifndef PFM_REGS_VH
`define PFM_REGS_VH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define PFM_OFF_MODE0 8'h00
`define PFM_OFF_MODE1 8'h04
`define PFM_OFF_AUX 8'h08
`define PFM_OFF_LATCH0 8'h0C
`define PFM_OFF_LATCH1 8'h10
`define PFM_OFF_LATCH2 8'h14
`define PFM_OFF_LATCH3 8'h18
`define PFM_OFF_LATCH4 8'h1C
`define PFM_OFF_LEVEL0 8'h20
`define PFM_OFF_LEVEL1 8'h24
`define PFM_OFF_LEVEL2 8'h28
`define PFM_OFF_LEVEL3 8'h2C
`define PFM_OFF_LEVEL4 8'h30
`define PFM_OFF_PLL_DIVIDER 8'hA4

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define PFM_PLL_R_MSB 7
`define PFM_PLL_R_LSB 4
`define PFM_PLL_N_MSB 3
`define PFM_PLL_N_LSB 0
`define PFM_M0_P3_LSB 6
`define PFM_M0_P2_LSB 4
`define PFM_M0_PRES_DISC 3
`define PFM_M0_P0_LSB 0
`define PFM_M1_P4_LSB 0
`define PFM_M1_LED_LSB 2
`define PFM_AUX_WPU_DIS 0
`define PFM_AUX_ALT_CLK_EN 1
`define PFM_AUX_SMART_CARD_INTERFACE_BLOCK_EN 2
`define PFM_AUX_SPI_EN 3

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define PFM_RST_PLL_DIVIDER 8'h00
`define PFM_RST_MODE 8'h00
`define PFM_RST_AUX 8'h00
`define PFM_RST_LATCH 8'hFF
`define PFM_RST_LATCH4 6'h3F

// ----------------------------------------------------------------
// pin drive kinds
// ----------------------------------------------------------------
`define PFM_K_QUASI 3'h0
`define PFM_K_OPEN_DRAIN 3'h1
`define PFM_K_PUSH_PULL 3'h2
`define PFM_K_LOW_SPEED 3'h3
`define PFM_K_WPU_IN 3'h4
`define PFM_K_LED 3'h5
`define PFM_K_MPU_IN 3'h6

`endif

// ===== design/pfm_pin_cell.v
/*
  One pad driver cell: turns a drive kind and a data bit into pad
  output, output enable and pull-up controls, all registered.
  Assumes pin_level_in is already synchronised on core_clk_in.
*/
`timescale 1ns/100ps
`default_nettype none
`include "pfm_regs.vh"

module pfm_pin_cell (
  input wire core_clk_in,
  input wire reset_in,
  input wire [2:0] kind_in,
  input wire data_in,
  input wire pin_level_in,
  input wire weak_dis_in,
  input wire medium_dis_in,
  output reg pin_out,
  output reg pin_oe_out,
  output reg weak_pu_out,
  output reg medium_pu_out,
  output reg slow_out,
  output reg led_out
);

  reg oe_d;
  reg weak_d;
  reg medium_d;

  // ----------------------------------------------------------------
  // drive decode
  // ----------------------------------------------------------------
  always @*
  begin
    oe_d = 1'b1;
    weak_d = 1'b0;
    medium_d = 1'b0;
    case (kind_in)
      `PFM_K_QUASI:
      begin
        oe_d = ~data_in;
        weak_d = data_in & ~weak_dis_in;
        medium_d = data_in & pin_level_in & ~medium_dis_in;
      end
      `PFM_K_OPEN_DRAIN: oe_d = ~data_in;
      `PFM_K_WPU_IN:
      begin
        oe_d = 1'b0;
        weak_d = 1'b1;
      end
      `PFM_K_MPU_IN:
      begin
        oe_d = 1'b0;
        weak_d = 1'b1;
        medium_d = pin_level_in;
      end
      default: oe_d = 1'b1;
    endcase
  end

  always @(posedge core_clk_in)
  begin
    if (reset_in)
    begin
      pin_out <= 1'b0;
      pin_oe_out <= 1'b0;
      weak_pu_out <= 1'b0;
      medium_pu_out <= 1'b0;
      slow_out <= 1'b0;
      led_out <= 1'b0;
    end
    else
    begin
      pin_out <= data_in;
      pin_oe_out <= oe_d;
      weak_pu_out <= weak_d;
      medium_pu_out <= medium_d;
      slow_out <= (kind_in == `PFM_K_LOW_SPEED);
      led_out <= (kind_in == `PFM_K_LED);
    end
  end

endmodule // pfm_pin_cell

`default_nettype wire

// ===== tb/pfm_pad_model.sv
/*
  Pad model closing the loop from pfm_top pad drive to pin_in.
  Assumes one core clock; the bench picks what external parts drive.
*/
`timescale 1ns/100ps
`default_nettype none
module pfm_pad_model (
  input wire core_clk_in,
  input wire [37:0] pin_out_in,
  input wire [37:0] pin_oe_in,
  input wire [37:0] pull_in,
  input wire [37:0] ext_en_in,
  input wire [37:0] ext_val_in,
  output wire [37:0] pad_out
);
  logic [37:0] junk_q = 38'h0;
  // ----------------------------------------------------------------
  // floating pads wander every cycle
  // ----------------------------------------------------------------
  always @(posedge core_clk_in)
    junk_q <= ~junk_q;
  assign pad_out = (pin_oe_in & pin_out_in)
    | (~pin_oe_in & ext_en_in & ext_val_in)
    | (~pin_oe_in & ~ext_en_in & (pull_in | junk_q));
endmodule // pfm_pad_model
`default_nettype wire

// ===== tb/pfm_top_asserts.sv
/*
  Port-level assertions for pfm_top.
  Assumes bind into pfm_top and a single clock domain.
*/
`timescale 1ns/100ps
`default_nettype none
module pfm_chk #(
  parameter N_PINS = 38
) (
  input wire core_clk_in,
  input wire reset_in,
  input wire psel_in,
  input wire penable_in,
  input wire pwrite_in,
  input wire [7:0] paddr_in,
  input wire [31:0] pwdata_in,
  input wire ext_mem_access_in,
  input wire ext_data_drive_in,
  input wire [7:0] ext_addr_data_lo_in,
  input wire [7:0] ext_addr_hi_in,
  input wire ext_wr_strobe_n_in,
  input wire ext_rd_strobe_n_in,
  input wire alternate_card_clock_in,
  input wire [N_PINS-1:0] pin_out,
  input wire [N_PINS-1:0] pin_oe_out,
  input wire [N_PINS-1:0] weak_pu_out,
  input wire [N_PINS-1:0] slow_out,
  input wire [3:0] pll_r_divider_out,
  input wire [3:0] pll_n_divider_out
);
  // ----------------------------------------------------------------
  // shadow of aux and mode0 registers
  // ----------------------------------------------------------------
  reg [7:0] aux_q;
  reg [7:0] mode0_q;
  wire wr_hit;
  assign wr_hit = psel_in & penable_in & pwrite_in;
  always @(posedge core_clk_in)
  begin
    if (reset_in)
    begin
      aux_q <= 8'h00;
      mode0_q <= 8'h00;
    end
    else if (wr_hit && paddr_in == 8'h08)
      aux_q <= pwdata_in[7:0];
    else if (wr_hit && paddr_in == 8'h00)
      mode0_q <= pwdata_in[7:0];
  end
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (reset_in);
  sequence s_pll_wr;
    wr_hit && paddr_in == 8'hA4;
  endsequence
  sequence s_release;
    $fell(reset_in) && !ext_mem_access_in;
  endsequence
  property p_pll_r;
    s_pll_wr |=> pll_r_divider_out == $past(pwdata_in[7:4]);
  endproperty
  a_pll_r: assert property (p_pll_r) else $error("pll r field wrong");
  property p_pll_n;
    s_pll_wr |=> pll_n_divider_out == $past(pwdata_in[3:0]);
  endproperty
  a_pll_n: assert property (p_pll_n) else $error("pll n field wrong");
  property p_pll_rst;
    $fell(reset_in) |-> {pll_r_divider_out, pll_n_divider_out} == 8'h00;
  endproperty
  a_pll_rst: assert property (p_pll_rst) else $error("pll not cleared");
  property p_p0_ext;
    ext_mem_access_in && ext_data_drive_in |=> pin_oe_out[7:0] == 8'hFF
      && pin_out[7:0] == $past(ext_addr_data_lo_in);
  endproperty
  a_p0_ext: assert property (p_p0_ext) else $error("port0 bus drive wrong");
  property p_p2_ext;
    ext_mem_access_in |=> pin_oe_out[23:16] == 8'hFF
      && pin_out[23:16] == $past(ext_addr_hi_in);
  endproperty
  a_p2_ext: assert property (p_p2_ext) else $error("port2 address wrong");
  property p_strobe;
    ext_mem_access_in |=> pin_out[30] == $past(ext_wr_strobe_n_in)
      && pin_out[31] == $past(ext_rd_strobe_n_in);
  endproperty
  a_strobe: assert property (p_strobe) else $error("strobe pins wrong");
  property p_default;
    s_release |=> pin_oe_out[7:0] == 8'h00 && pin_oe_out[13:11] == 3'h7
      && pin_oe_out[9:8] == 2'h3 && pin_out[13:11] == 3'h0 && weak_pu_out[10]
      && pin_oe_out[23:16] == 8'h00;
  endproperty
  a_default: assert property (p_default) else $error("reset pad defaults wrong");
  property p_p0_slow;
    mode0_q[1:0] == 2'h2 && !ext_mem_access_in |=> slow_out[7:0] == 8'hFF;
  endproperty
  a_p0_slow: assert property (p_p0_slow) else $error("port0 low speed off");
  property p_alt;
    aux_q[1] |=> pin_oe_out[15] && pin_out[15] == $past(alternate_card_clock_in);
  endproperty
  a_alt: assert property (p_alt) else $error("alt clock pin wrong");
  property p_wpu;
    aux_q[0] |=> {weak_pu_out[11], weak_pu_out[9:8]} == 3'h0;
  endproperty
  a_wpu: assert property (p_wpu) else $error("card weak pull-up on");
endmodule // pfm_chk
bind pfm_top pfm_chk #(.N_PINS(N_PINS)) u_pfm_chk (
  .core_clk_in(core_clk_in), .reset_in(reset_in), .psel_in(psel_in),
  .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
  .pwdata_in(pwdata_in), .ext_mem_access_in(ext_mem_access_in),
  .ext_data_drive_in(ext_data_drive_in), .ext_addr_data_lo_in(ext_addr_data_lo_in),
  .ext_addr_hi_in(ext_addr_hi_in), .ext_wr_strobe_n_in(ext_wr_strobe_n_in),
  .ext_rd_strobe_n_in(ext_rd_strobe_n_in),
  .alternate_card_clock_in(alternate_card_clock_in), .pin_out(pin_out),
  .pin_oe_out(pin_oe_out), .weak_pu_out(weak_pu_out), .slow_out(slow_out),
  .pll_r_divider_out(pll_r_divider_out), .pll_n_divider_out(pll_n_divider_out)
);
`default_nettype wire

// ===== tb/pfm_top_tb.sv
/*
  Self-checking bench for pfm_top over APB.
  Assumes pfm_pad_model resolves every pad.
*/
`timescale 1ns/100ps
`default_nettype none
module pfm_top_tb;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0;
  logic pen = 1'b0;
  logic pwr = 1'b0;
  logic acc = 1'b0;
  logic drv = 1'b0;
  logic wr_n = 1'b1;
  logic rd_n = 1'b1;
  logic alt = 1'b0;
  logic [7:0] pa = 8'h00;
  logic [31:0] pwd = 32'h0;
  logic [7:0] lo = 8'h00;
  logic [7:0] hi = 8'h00;
  logic [4:0] card = 5'h00;
  logic [2:0] sd = 3'h0;
  logic [2:0] so = 3'h0;
  logic [37:0] xen = 38'h0;
  logic [37:0] xval = 38'h0;
  logic [31:0] rd;
  logic rerr;
  int failures = 0;
  int n_checks = 0;
  wire prdy, perr;
  wire [31:0] prd;
  wire [7:0] xrd;
  wire [3:0] pr, pn;
  wire [37:0] pin, po, oe, weak_pullup_input, mpu, slw, led, lvl;
  pfm_top u_pfm_top (
    .core_clk_in(clk), .reset_in(rst), .psel_in(psel), .penable_in(pen),
    .pwrite_in(pwr), .paddr_in(pa), .pwdata_in(pwd), .pready_out(prdy),
    .prdata_out(prd), .pslverr_out(perr), .ext_mem_access_in(acc),
    .ext_data_drive_in(drv), .ext_addr_data_lo_in(lo), .ext_addr_hi_in(hi),
    .ext_wr_strobe_n_in(wr_n), .ext_rd_strobe_n_in(rd_n), .ext_read_data_out(xrd),
    .card_io_line_in(card[0]), .card_contact_eight_in(card[1]),
    .card_contact_four_in(card[2]), .card_clock_out_in(card[3]),
    .card_reset_out_in(card[4]), .alternate_card_clock_in(alt),
    .spi_data_in(sd), .spi_oe_in(so), .pin_in(pin), .pin_out(po), .pin_oe_out(oe),
    .weak_pu_out(weak_pullup_input), .medium_pu_out(mpu), .slow_out(slw), .led_out(led),
    .pin_level_out(lvl), .pll_r_divider_out(pr), .pll_n_divider_out(pn)
  );
  pfm_pad_model u_pfm_pad_model (
    .core_clk_in(clk), .pin_out_in(po), .pin_oe_in(oe), .pull_in(weak_pullup_input | mpu),
    .ext_en_in(xen), .ext_val_in(xval), .pad_out(pin)
  );
  initial
    forever #5 clk = ~clk;
  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task report_and_stop;
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task chk(input logic [63:0] got, input logic [63:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      failures++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    pa <= a;
    pwd <= d;
    @(posedge clk);
    pen <= 1'b1;
    for (k = 0; k < 16; k++)
    begin
      @(posedge clk);
      if (prdy === 1'b1)
        break;
    end
    if (k == 16)
    begin
      failures++;
      report_and_stop;
    end
    rd = prd;
    rerr = perr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask
  task settle;
    repeat (2) @(posedge clk);
    #1;
  endtask
  task wrs(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
    settle;
  endtask
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task t_defaults;
    apb(1'b0, 8'hA4, 32'h0);
    chk(rd, 32'h0);
    chk(oe[7:0], 8'h00);
    chk({oe[8], po[8]}, 2'b10);
    chk({oe[10], weak_pullup_input[10]}, 2'b01);
    chk({oe[13:12], po[13:12]}, 4'hC);
    chk({oe[14], weak_pullup_input[14]}, 2'b01);
    chk({oe[37:16], weak_pullup_input[37:16]}, 44'h3FFFFF);
  endtask
  task t_pll;
    apb(1'b1, 8'hA4, 32'hA5);
    apb(1'b0, 8'hA4, 32'h0);
    chk({rd, pr, pn}, 40'hA5A5);
    apb(1'b0, 8'h40, 32'h0);
    chk({rerr, rd}, 33'h100000000);
    apb(1'b1, 8'h20, 32'h0);
    chk(rerr, 1'b1);
  endtask
  task t_modes;
    wrs(8'h00, 32'h03);
    chk({oe[7:0], po[7:0]}, 16'hFFFF);
    wrs(8'h00, 32'h02);
    chk(slw[7:0], 8'hFF);
    wrs(8'h00, 32'h10);
    chk(oe[23:16], 8'hFF);
    wrs(8'h00, 32'h20);
    chk(slw[23:16], 8'hFF);
    wrs(8'h00, 32'h70);
    chk({oe[23:16], weak_pullup_input[23:16]}, 16'h00FF);
    chk(oe[28:24], 5'h1B);
    wrs(8'h00, 32'h88);
    chk(slw[28:24], 5'h1B);
    chk({weak_pullup_input[10], mpu[10]}, 2'b00);
    wrs(8'h00, 32'h00);
    wrs(8'h0C, 32'h0F);
    chk(oe[7:0], 8'hF0);
    wrs(8'h0C, 32'hFF);
    wrs(8'h10, 32'hFB);
    chk({oe[10], po[10], oe[8]}, 3'b101);
    wrs(8'h10, 32'hFF);
  endtask
  task t_ext;
    @(posedge clk);
    acc <= 1'b1;
    drv <= 1'b1;
    lo <= 8'hA5;
    hi <= 8'h3C;
    wr_n <= 1'b0;
    settle;
    chk({oe[7:0], po[7:0]}, 16'hFFA5);
    chk({oe[23:16], po[23:16]}, 16'hFF3C);
    chk(po[31:30], 2'b10);
    @(posedge clk);
    drv <= 1'b0;
    wr_n <= 1'b1;
    rd_n <= 1'b0;
    xen <= 38'hFF;
    xval <= 38'h5A;
    repeat (7) @(posedge clk);
    #1;
    chk({oe[7:0], xrd, lvl[7:0]}, 24'h005A5A);
    chk(po[31:30], 2'b01);
    apb(1'b0, 8'h20, 32'h0);
    chk(rd, 32'h5A);
    @(posedge clk);
    acc <= 1'b0;
    rd_n <= 1'b1;
    xen <= 38'h0;
  endtask
  task t_card;
    @(posedge clk);
    card <= 5'b01111;
    alt <= 1'b1;
    wrs(8'h08, 32'h04);
    chk({oe[8], weak_pullup_input[8]}, 2'b01);
    chk({oe[12], po[12], oe[13], po[13]}, 4'b1110);
    wrs(8'h08, 32'h05);
    chk({weak_pullup_input[11], weak_pullup_input[9:8]}, 3'h0);
    wrs(8'h08, 32'h02);
    chk({oe[15], po[15]}, 2'b11);
    @(posedge clk);
    alt <= 1'b0;
    settle;
    chk({oe[15], po[15]}, 2'b10);
    wrs(8'h08, 32'h08);
    @(posedge clk);
    so <= 3'h3;
    sd <= 3'h5;
    settle;
    chk({oe[34:32], po[33:32]}, 5'h0D);
    chk(oe[15], 1'b0);
    wrs(8'h08, 32'h00);
  endtask
  task t_port4;
    apb(1'b0, 8'h1C, 32'h0);
    chk(rd, 32'h3F);
    wrs(8'h04, 32'h01);
    chk(oe[37:32], 6'h38);
    wrs(8'h04, 32'h3C);
    chk({led[31:30], led[28], led[26], led[27]}, 5'h1E);
    wrs(8'h04, 32'h03);
    chk({oe[37:35], weak_pullup_input[37:35], mpu[37:35]}, 9'h03F);
    wrs(8'h04, 32'h00);
  endtask
  initial
  begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    settle;
    t_defaults;
    t_pll;
    t_modes;
    t_ext;
    t_card;
    t_port4;
    @(posedge clk);
    rst <= 1'b1;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    settle;
    t_defaults;
    report_and_stop;
  end
endmodule // pfm_top_tb
`default_nettype wire
